// ===== include/dpgpio_pkg.sv
/*
  Constants, register map and carrier types for the dual port gpio module.
  Assumes an APB master on the same clock and a pin multiplexer outside.
*/
// Function
// [RQ1] The module is an APB slave and every data and direction register is reached over it.
// [RQ2] Ports A to J are seven 8-bit ports, two 7-bit ports (D, F) and one 6-bit port (B).
// [RQ3] Every port but J has per-pin direction control, and port J only samples its pins.
// [RQ4] Offsets are first data 0x00, second data 0x04, first direction 0x08, second direction 0x0C.
// [RQ5] In the module with the input-only port, offset 0x0C is reserved and has no register.
// [RQ6] Data register bits drive the pins whose direction bit is 1, and other pins are not driven.
// [RQ7] A data read returns the last written value for bits set as outputs.
// [RQ8] A data read returns the present pin level for bits set as inputs.
// [RQ9] A direction bit of 1 makes its pin an output and 0 makes it an input.
// [RQ10] System reset clears all data and direction registers, so all pins start as inputs.
// [RQ11] A direction bit controls its pin only while the multiplexer selects the gpio function.
// [RQ12] The first port implements bits 7:0 and reads bits 31:8 as zero.
// [RQ13] A 6-pin port implements only bits 5:0, and bits 31:6 read as zero.
// [RQ14] Input pin levels pass a two-flop synchroniser before they reach the read data path.
package dpgpio_pkg;

  localparam int unsigned DPGPIO_AW   = 4;
  localparam int unsigned DPGPIO_DW   = 32;
  localparam int unsigned DPGPIO_PW   = 8;

  // register offsets within one module
  localparam logic [DPGPIO_AW-1:0] DPGPIO_FIRST_DATA_OFS  = 4'h0;
  localparam logic [DPGPIO_AW-1:0] DPGPIO_SECOND_DATA_OFS = 4'h4;
  localparam logic [DPGPIO_AW-1:0] DPGPIO_FIRST_DIR_OFS   = 4'h8;
  localparam logic [DPGPIO_AW-1:0] DPGPIO_SECOND_DIR_OFS  = 4'hc;

  localparam logic [DPGPIO_PW-1:0] DPGPIO_PORT_RST = 8'h00;
  localparam logic [DPGPIO_DW-1:0] DPGPIO_RD_ZERO  = 32'h0000_0000;

  // port widths A..J
  localparam int unsigned DPGPIO_W_A = 8;
  localparam int unsigned DPGPIO_W_B = 6;
  localparam int unsigned DPGPIO_W_C = 8;
  localparam int unsigned DPGPIO_W_D = 7;
  localparam int unsigned DPGPIO_W_E = 8;
  localparam int unsigned DPGPIO_W_F = 7;
  localparam int unsigned DPGPIO_W_G = 8;
  localparam int unsigned DPGPIO_W_H = 8;
  localparam int unsigned DPGPIO_W_I = 8;
  localparam int unsigned DPGPIO_W_J = 8;

  // apb request as seen by the slave
  typedef struct packed {
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [DPGPIO_AW-1:0] paddr;
    logic [DPGPIO_DW-1:0] pwdata;
  } dpgpio_apb_req_t;

  // one port's pin drive: level and enable
  typedef struct packed {
    logic [DPGPIO_PW-1:0] level;
    logic [DPGPIO_PW-1:0] oe;
  } dpgpio_pin_drv_t;

endpackage : dpgpio_pkg

// ===== logic/dpgpio_module.sv
/*
  Dual port gpio module: apb slave with two ports and four register words.
  Assumes a zero-wait apb master on mclk_i and an external pin multiplexer
  giving one alternate-function select bit per pin.
*/
`timescale 1ns/1ns
`default_nettype none
module dpgpio_module
  import dpgpio_pkg::*;
#(
  parameter int unsigned FIRST_W      = DPGPIO_W_A, // RQ2
  parameter int unsigned SECOND_W     = DPGPIO_W_B, // RQ2
  parameter bit          SECOND_INPUT = 1'b0
)(
  input  wire logic                     mclk_i,
  input  wire logic                     srst_i,
  input  wire dpgpio_pkg::dpgpio_apb_req_t apb_i,
  output var  logic [DPGPIO_DW-1:0]     prdata_o,
  output var  logic                     pready_o,
  output var  logic                     pslverr_o,
  input  wire logic [DPGPIO_PW-1:0]     first_port_pins_i,
  input  wire logic [DPGPIO_PW-1:0]     second_port_pins_i,
  input  wire logic [DPGPIO_PW-1:0]     first_alt_sel_i,
  input  wire logic [DPGPIO_PW-1:0]     second_alt_sel_i,
  output var  dpgpio_pkg::dpgpio_pin_drv_t first_port_pins_o,
  output var  dpgpio_pkg::dpgpio_pin_drv_t second_port_pins_o
);
  import dpgpio_pkg::*;

  logic                 wr_acc;
  logic                 setup;
  logic [DPGPIO_PW-1:0] first_rd;
  logic [DPGPIO_PW-1:0] second_rd;
  logic [DPGPIO_PW-1:0] first_dir;
  logic [DPGPIO_PW-1:0] second_dir;
  logic [DPGPIO_DW-1:0] rd_d;

  // writes land in the access phase
  assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite; // RQ1
  assign setup  = apb_i.psel && !apb_i.penable;

  dpgpio_port #(
    .WIDTH   (FIRST_W),
    .HAS_DIR (1'b1)
  ) u_first (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .data_we_i (wr_acc && apb_i.paddr == DPGPIO_FIRST_DATA_OFS), // RQ4
    .dir_we_i  (wr_acc && apb_i.paddr == DPGPIO_FIRST_DIR_OFS),
    .wdata_i   (apb_i.pwdata[DPGPIO_PW-1:0]),
    .pin_i     (first_port_pins_i),
    .alt_sel_i (first_alt_sel_i),
    .rdata_o   (first_rd),
    .dir_o     (first_dir),
    .drv_o     (first_port_pins_o)
  );

  // input-only second port gets no direction register
  dpgpio_port #(
    .WIDTH   (SECOND_W),
    .HAS_DIR (!SECOND_INPUT)
  ) u_second (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .data_we_i (wr_acc && apb_i.paddr == DPGPIO_SECOND_DATA_OFS),
    .dir_we_i  (wr_acc && apb_i.paddr == DPGPIO_SECOND_DIR_OFS), // RQ5 RQ3
    .wdata_i   (apb_i.pwdata[DPGPIO_PW-1:0]),
    .pin_i     (second_port_pins_i),
    .alt_sel_i (second_alt_sel_i),
    .rdata_o   (second_rd),
    .dir_o     (second_dir),
    .drv_o     (second_port_pins_o)
  );

  // read decode; reserved and unmapped words read zero
  always_comb
  begin
    rd_d = DPGPIO_RD_ZERO;
    case (apb_i.paddr)
      DPGPIO_FIRST_DATA_OFS:  rd_d = {24'h00_0000, first_rd}; // RQ12
      DPGPIO_SECOND_DATA_OFS: rd_d = {24'h00_0000, second_rd};
      DPGPIO_FIRST_DIR_OFS:   rd_d = {24'h00_0000, first_dir};
      DPGPIO_SECOND_DIR_OFS:  rd_d = SECOND_INPUT ? DPGPIO_RD_ZERO
                                                  : {24'h00_0000, second_dir}; // RQ5
      default:                rd_d = DPGPIO_RD_ZERO;
    endcase
  end

  // read data captured in setup, shown in the access phase; one wait-free answer
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      prdata_o <= DPGPIO_RD_ZERO;
    else if (setup && !apb_i.pwrite)
      prdata_o <= rd_d; // RQ1
  end

  // ready is registered so it stands only in the access phase
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      pready_o <= 1'b0;
    else
      pready_o <= setup;
  end

  // no error cases in this block
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      pslverr_o <= 1'b0;
    else
      pslverr_o <= 1'b0;
  end

  sequence s_setup;
    apb_i.psel && !apb_i.penable;
  endsequence

  AST_READY_ACCESS: assert property (@(posedge mclk_i) disable iff (srst_i) // RQ1
    s_setup |=> pready_o)
    else $error("ready missing in access phase");
  AST_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (srst_i) // RQ5
    (s_setup and (!apb_i.pwrite && SECOND_INPUT && apb_i.paddr == DPGPIO_SECOND_DIR_OFS))
    |=> prdata_o == DPGPIO_RD_ZERO)
    else $error("reserved word read nonzero");
  AST_FIRST_UPPER: assert property (@(posedge mclk_i) disable iff (srst_i) // RQ12
    (s_setup and (!apb_i.pwrite && apb_i.paddr == DPGPIO_FIRST_DATA_OFS))
    |=> prdata_o[DPGPIO_DW-1:DPGPIO_PW] == '0)
    else $error("upper bits not zero");
  AST_OUT_READBACK: assert property (@(posedge mclk_i) disable iff (srst_i) // RQ7
    (wr_acc && apb_i.paddr == DPGPIO_FIRST_DATA_OFS)
    |=> (first_rd & first_dir) == ($past(apb_i.pwdata[DPGPIO_PW-1:0]) & first_dir))
    else $error("output bit readback wrong");
  AST_DRIVE_LEVEL: assert property (@(posedge mclk_i) disable iff (srst_i) // RQ6
    (wr_acc && apb_i.paddr == DPGPIO_FIRST_DATA_OFS) |=> ##1
    first_port_pins_o.level == ($past(apb_i.pwdata[DPGPIO_PW-1:0], 2) & 8'(FIRST_W == 8 ? 8'hff : 8'h3f)))
    else $error("pin level not written data");
  AST_RESET_INPUT: assert property (@(posedge mclk_i) // RQ10
    $past(srst_i) |-> first_dir == '0 && second_dir == '0)
    else $error("direction not cleared by reset");
  AST_NO_DRIVE_IN: assert property (@(posedge mclk_i) disable iff (srst_i) // RQ9
    (second_dir == '0) |=> second_port_pins_o.oe == '0)
    else $error("input pin driven");
  AST_SECOND_ONLY_IN: assert property (@(posedge mclk_i) disable iff (srst_i) // RQ3
    SECOND_INPUT |-> second_port_pins_o.oe == '0)
    else $error("input-only port driven");

endmodule : dpgpio_module
`default_nettype wire

// ===== logic/dpgpio_port.sv
/*
  One gpio port: data and direction registers, pin synchroniser, read value.
  Assumes register strobes from the apb decode on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module dpgpio_port
  import dpgpio_pkg::*;
#(
  parameter int unsigned WIDTH     = 8,
  parameter bit          HAS_DIR   = 1'b1
)(
  input  wire logic                     mclk_i,
  input  wire logic                     srst_i,
  input  wire logic                     data_we_i,
  input  wire logic                     dir_we_i,
  input  wire logic [DPGPIO_PW-1:0]     wdata_i,
  input  wire logic [DPGPIO_PW-1:0]     pin_i,
  input  wire logic [DPGPIO_PW-1:0]     alt_sel_i,
  output var  logic [DPGPIO_PW-1:0]     rdata_o,
  output var  logic [DPGPIO_PW-1:0]     dir_o,
  output var  dpgpio_pkg::dpgpio_pin_drv_t drv_o
);

  // per-port pin count; bits above it never store and read zero
  localparam logic [DPGPIO_PW-1:0] IMPL_MASK = DPGPIO_PW'((1 << WIDTH) - 1); // RQ2 RQ13

  logic [DPGPIO_PW-1:0] data_q;
  logic [DPGPIO_PW-1:0] dir_q;
  logic [DPGPIO_PW-1:0] sync1_q;
  logic [DPGPIO_PW-1:0] sync2_q;

  // data register, unimplemented bits never store
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      data_q <= DPGPIO_PORT_RST; // RQ10
    else if (data_we_i)
      data_q <= wdata_i & IMPL_MASK; // RQ12 RQ13
  end

  // direction register, absent on the input-only port
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      dir_q <= DPGPIO_PORT_RST; // RQ10
    else if (dir_we_i && HAS_DIR)
      dir_q <= wdata_i & IMPL_MASK; // RQ9 RQ3
  end

  // two flops before any logic sees a pin
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      sync1_q <= DPGPIO_PORT_RST;
      sync2_q <= DPGPIO_PORT_RST;
    end
    else
    begin
      sync1_q <= pin_i; // RQ14
      sync2_q <= sync1_q;
    end
  end

  // pin drive registered so top outputs come from flops; alt function wins
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      drv_o <= '0;
    else
    begin
      drv_o.level <= data_q;
      drv_o.oe    <= dir_q & ~alt_sel_i; // RQ6 RQ11
    end
  end

  // read mux per bit: output bits show the register, inputs the pin
  assign rdata_o = ((dir_q & data_q) | (~dir_q & sync2_q)) & IMPL_MASK; // RQ7 RQ8 RQ13
  assign dir_o   = dir_q;

  AST_OE_FOLLOWS_DIR: assert property (@(posedge mclk_i) disable iff (srst_i) // RQ11
    ##1 drv_o.oe == ($past(dir_q) & ~$past(alt_sel_i)))
    else $error("pin enable does not follow direction and mux");
  AST_UPPER_ZERO: assert property (@(posedge mclk_i) disable iff (srst_i) // RQ13
    ((rdata_o | dir_q) & ~IMPL_MASK) == '0)
    else $error("unimplemented bits not zero");
  AST_INPUT_SYNC: assert property (@(posedge mclk_i) disable iff (srst_i) // RQ14
    (dir_q == '0) |-> rdata_o == (sync2_q & IMPL_MASK))
    else $error("input read not synchronised pin");

endmodule : dpgpio_port
`default_nettype wire

// ===== verif/dpgpio_apb_bfm.sv
/*
  APB master model standing in for the processor in front of the gpio module.
  Assumes a slave on mclk_i that answers with pready in the access phase.
*/
`timescale 1ns/1ns
`default_nettype none
module dpgpio_apb_bfm
  import dpgpio_pkg::*;
(
  input  wire logic                        mclk_i,
  input  wire logic [DPGPIO_DW-1:0]        prdata_i,
  input  wire logic                        pready_i,
  output var  dpgpio_pkg::dpgpio_apb_req_t req_o
);
  initial req_o = '0;

  // one transfer; changes only after falling edges, holds until pready is seen or 16 more rising edges pass
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    rd = 'x;
    @(negedge mclk_i);
    req_o <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: {24'h0, wd}};
    @(negedge mclk_i);
    req_o.penable <= 1'h1;
    @(posedge mclk_i);
    while (pready_i !== 1'h1 && n < 16)
    begin
      n++;
      @(posedge mclk_i);
    end
    if (n < 16)
      rd = prdata_i;
    @(negedge mclk_i);
    // released lines flip so a stale value never passes for a fresh one
    req_o <= '{psel: 1'h0, penable: 1'h0, pwrite: ~wr, paddr: ~a, pwdata: ~{24'h0, wd}};
  endtask : xfer
endmodule : dpgpio_apb_bfm
`default_nettype wire

// ===== verif/tb_dual_port_gpio_module.sv
/*
  Self-checking bench: a six-pin module (A/B) and the input-only module (I/J).
  Assumes the pad model here resolves each pin from the module drive.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_dual_port_gpio_module;
  import dpgpio_pkg::*;
  logic            mclk_i = 1'h0;
  logic            srst_i = 1'h1;
  int              failures = 0;
  int              compares = 0;
  logic [7:0]      ext_a = 8'h5a, ext_b = 8'h21, ext_i = 8'hc3, ext_j = 8'h96;
  logic [7:0]      alt_a = 8'h00, alt_b = 8'h00, alt_i = 8'h00, alt_j = 8'h00;
  logic [31:0]     rd, prd_ab, prd_ij;
  logic            rdy_ab, rdy_ij, err_ab, err_ij;
  dpgpio_apb_req_t req_ab, req_ij;
  dpgpio_pin_drv_t drv_a, drv_b, drv_i, drv_j;
  // pad model: a driven pin shows the drive, otherwise the outside level
  wire logic [7:0] pad_a = (drv_a.oe & drv_a.level) | (~drv_a.oe & ext_a);
  wire logic [7:0] pad_b = (drv_b.oe & drv_b.level) | (~drv_b.oe & ext_b);
  wire logic [7:0] pad_i = (drv_i.oe & drv_i.level) | (~drv_i.oe & ext_i);
  wire logic [7:0] pad_j = (drv_j.oe & drv_j.level) | (~drv_j.oe & ext_j);

  always #5 mclk_i = ~mclk_i;

  // defaults give the a/b widths; only the i/j module overrides them
  dpgpio_module dpgpio_module_i (
    .mclk_i(mclk_i), .srst_i(srst_i), .apb_i(req_ab), .prdata_o(prd_ab), .pready_o(rdy_ab),
    .pslverr_o(err_ab), .first_port_pins_i(pad_a), .second_port_pins_i(pad_b),
    .first_alt_sel_i(alt_a), .second_alt_sel_i(alt_b),
    .first_port_pins_o(drv_a), .second_port_pins_o(drv_b));
  dpgpio_module #(.SECOND_W(8), .SECOND_INPUT(1'h1)) dpgpio_module_ij_i (
    .mclk_i(mclk_i), .srst_i(srst_i), .apb_i(req_ij), .prdata_o(prd_ij), .pready_o(rdy_ij),
    .pslverr_o(err_ij), .first_port_pins_i(pad_i), .second_port_pins_i(pad_j),
    .first_alt_sel_i(alt_i), .second_alt_sel_i(alt_j),
    .first_port_pins_o(drv_i), .second_port_pins_o(drv_j));
  dpgpio_apb_bfm dpgpio_apb_bfm_i (.mclk_i(mclk_i), .prdata_i(prd_ab), .pready_i(rdy_ab),
    .req_o(req_ab));
  dpgpio_apb_bfm dpgpio_apb_bfm_ij_i (.mclk_i(mclk_i), .prdata_i(prd_ij), .pready_i(rdy_ij),
    .req_o(req_ij));

  // direction words clear and nothing driven after reset
  task automatic t_reset;
    dpgpio_apb_bfm_i.xfer(1'h0, 4'h8, 8'h00, rd);
    `CHK(rd, 32'h0)
    dpgpio_apb_bfm_i.xfer(1'h0, 4'hc, 8'h00, rd);
    `CHK(rd, 32'h0)
    `CHK(drv_a.oe | drv_b.oe, 8'h00)
    dpgpio_apb_bfm_i.xfer(1'h0, 4'h0, 8'h00, rd);
    `CHK(rd, {24'h0, ext_a})
  endtask : t_reset

  // mixed directions: outputs read back stored bits, inputs read the pins
  task automatic t_dir;
    dpgpio_apb_bfm_i.xfer(1'h1, 4'h8, 8'hff, rd);
    dpgpio_apb_bfm_i.xfer(1'h0, 4'h0, 8'h00, rd);
    `CHK(rd, 32'h0)
    dpgpio_apb_bfm_i.xfer(1'h1, 4'h0, 8'h3c, rd);
    dpgpio_apb_bfm_i.xfer(1'h1, 4'h8, 8'ha5, rd);
    repeat (3) @(negedge mclk_i);
    `CHK(drv_a.oe, 8'ha5)
    `CHK(drv_a.level & 8'ha5, 8'h24)
    dpgpio_apb_bfm_i.xfer(1'h0, 4'h0, 8'h00, rd);
    `CHK(rd, {24'h0, 8'h24 | (ext_a & 8'h5a)})
    dpgpio_apb_bfm_i.xfer(1'h0, 4'h8, 8'h00, rd);
    `CHK(rd, 32'h0000_00a5)
  endtask : t_dir

  // six-pin port keeps only bits 5:0
  task automatic t_six;
    dpgpio_apb_bfm_i.xfer(1'h1, 4'hc, 8'hff, rd);
    dpgpio_apb_bfm_i.xfer(1'h0, 4'hc, 8'h00, rd);
    `CHK(rd, 32'h0000_003f)
    dpgpio_apb_bfm_i.xfer(1'h1, 4'h4, 8'hff, rd);
    dpgpio_apb_bfm_i.xfer(1'h0, 4'h4, 8'h00, rd);
    `CHK(rd, 32'h0000_003f)
    `CHK(drv_b.oe, 8'h3f)
  endtask : t_six

  // alternate function takes the pin away from the direction bit
  task automatic t_alt;
    alt_a = 8'hf0;
    alt_b = 8'h0f;
    repeat (3) @(negedge mclk_i);
    `CHK(drv_a.oe, 8'h05)
    `CHK(drv_b.oe, 8'h30)
    alt_a = 8'h00;
    alt_b = 8'h00;
    repeat (3) @(negedge mclk_i);
    `CHK(drv_a.oe, 8'ha5)
    `CHK(drv_b.oe, 8'h3f)
  endtask : t_alt

  // input-only port: no direction word, never drives, reads pins
  task automatic t_ij;
    dpgpio_apb_bfm_ij_i.xfer(1'h1, 4'hc, 8'hff, rd);
    dpgpio_apb_bfm_ij_i.xfer(1'h0, 4'hc, 8'h00, rd);
    `CHK(rd, 32'h0)
    dpgpio_apb_bfm_ij_i.xfer(1'h1, 4'h4, 8'hff, rd);
    dpgpio_apb_bfm_ij_i.xfer(1'h0, 4'h4, 8'h00, rd);
    `CHK(rd, {24'h0, ext_j})
    `CHK(drv_j.oe, 8'h00)
    dpgpio_apb_bfm_ij_i.xfer(1'h1, 4'h8, 8'h0f, rd);
    dpgpio_apb_bfm_ij_i.xfer(1'h0, 4'h8, 8'h00, rd);
    `CHK(rd, 32'h0000_000f)
    // mux owns two port i pins; port j stays undriven whatever the mux says
    alt_i = 8'h03;
    alt_j = 8'hff;
    repeat (3) @(negedge mclk_i);
    `CHK(drv_i.oe, 8'h0c)
    `CHK(drv_j.oe, 8'h00)
    dpgpio_apb_bfm_ij_i.xfer(1'h0, 4'h0, 8'h00, rd);
    `CHK(rd, {24'h0, ext_i & 8'hf0})
    dpgpio_apb_bfm_ij_i.xfer(1'h0, 4'h2, 8'h00, rd);
    `CHK(rd, 32'h0)
  endtask : t_ij

  // second reset mid-run: stored data and directions must clear again
  task automatic t_rerun;
    srst_i = 1'h1;
    repeat (2) @(negedge mclk_i);
    srst_i = 1'h0;
    `CHK(drv_a.oe | drv_i.oe, 8'h00)
    dpgpio_apb_bfm_i.xfer(1'h0, 4'h8, 8'h00, rd);
    `CHK(rd, 32'h0)
    dpgpio_apb_bfm_i.xfer(1'h0, 4'h0, 8'h00, rd);
    `CHK(rd, {24'h0, ext_a})
    `CHK(drv_a.level, 8'h00)
    dpgpio_apb_bfm_i.xfer(1'h1, 4'h8, 8'hff, rd);
    dpgpio_apb_bfm_i.xfer(1'h0, 4'h0, 8'h00, rd);
    `CHK(rd, 32'h0)
    `CHK({err_ab, err_ij}, 2'h0)
  endtask : t_rerun

  task automatic tally_and_finish;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (8) @(negedge mclk_i);
    srst_i = 1'h0;
    t_reset();
    t_dir();
    t_six();
    t_alt();
    t_ij();
    t_rerun();
    tally_and_finish();
  end

  // the whole run needs about a hundred cycles; far beyond that means a hang
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    failures++;
    tally_and_finish();
  end
endmodule : tb_dual_port_gpio_module
`default_nettype wire
